// ===== rtl/acq_chain_settle_and_pump_ctrl.sv
// Acquisition chain control: config registers, gain-stage reset, mux switching, settling and charge pump
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module acq_chain_settle_and_pump_ctrl
	import acq_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Analog front end control
	output logic            o_stage_rst,
	output logic      [2:0] o_stage_en,
	output logic            o_conv_en,
	output logic      [4:0] o_channel_mux_select,
	output logic            o_voltage_mux_select,
	output logic            o_input_switch,
	output logic      [1:0] o_amp_bias_current,
	output logic      [1:0] o_modulator_bias_current,
	output logic      [2:0] o_oversampling_ratio,
	output logic      [2:0] o_elementary_conversion_count,
	output logic            o_conv_start,
	output logic            o_settled,
	// Charge pump
	output logic            o_pump_en,
	output logic            o_pump_tick,
	output logic            o_pump_phase
);
	logic [7:0]    cfg_reg [NUM_CFG_REGS];
	logic [7:0]    charge_pump_config_reg;
	logic          cfg_wr;
	logic [2:0]    cfg_idx;
	logic [1:0]    rst_cnt_reg;
	logic [10:0]   settle_cnt_reg;
	logic [10:0]   osr_cycles;
	settle_state_t state_reg;
	logic          early_start_reg;
	logic          mux_changed;
	logic          bypassed;
	logic          bypass_next;
	logic          start_wr;
	logic [10:0]   low_cnt_reg;

	assign cfg_wr  = i_wr && i_addr >= ADDR_ACQ_CFG1 && i_addr <= ADDR_ACQ_CFG5;
	assign cfg_idx = 3'(i_addr - ADDR_ACQ_CFG1);

	// Configuration registers, one per generate entry
	genvar g;
	generate
		for (g = 0; g < NUM_CFG_REGS; g++) begin : g_cfg
			always_ff @(posedge i_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					cfg_reg[g] <= CFG_RESET;
				end else if (cfg_wr && cfg_idx == 3'(g)) begin
					cfg_reg[g] <= i_wdata;
				end
			end
		end
	endgenerate

	// Pump config, cleared on reset so the pump starts disabled
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			charge_pump_config_reg <= PUMP_CFG_RESET;
		end else if (i_wr && i_addr == ADDR_PUMP_CFG) begin
			charge_pump_config_reg <= {5'h00, i_wdata[2:0]};
		end
	end

	// Field decode
	assign bypassed                      = cfg_reg[0][3:0] == STAGES_BYPASSED;
	assign o_conv_en                     = cfg_reg[0][STAGE_EN_LSB];
	assign o_stage_en                    = bypassed ? 3'h0 : cfg_reg[0][3:1];
	assign o_channel_mux_select          = cfg_reg[1][CHAN_SEL_LSB +: 5];
	assign o_voltage_mux_select          = cfg_reg[1][VOLT_SEL_BIT];
	assign o_oversampling_ratio          = cfg_reg[2][RATIO_LSB +: 3];
	assign o_elementary_conversion_count = cfg_reg[2][NCONV_LSB +: 3];
	assign o_amp_bias_current            = cfg_reg[3][AMP_IB_LSB +: 2];
	assign o_modulator_bias_current      = cfg_reg[3][MOD_IB_LSB +: 2];
	assign o_pump_en                     = charge_pump_config_reg[PUMP_EN_BIT];
	assign osr_cycles                    = 11'(RATIO_MIN_CYC) << o_oversampling_ratio;

	// Mux change detect: only a real change switches the input
	assign mux_changed = cfg_wr && cfg_idx == 3'd1 &&
		i_wdata[5:0] != cfg_reg[1][5:0];

	// Gain-stage reset pulse after any config write
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_cnt_reg <= 2'h0;
		end else if (cfg_wr) begin
			rst_cnt_reg <= 2'(STAGE_RST_CYC);
		end else if (rst_cnt_reg != 2'h0) begin
			rst_cnt_reg <= rst_cnt_reg - 2'h1;
		end
	end
	assign o_stage_rst = rst_cnt_reg != 2'h0;

	// Input switch strobe
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_input_switch <= 1'b0;
		end else begin
			o_input_switch <= mux_changed;
		end
	end

	// Settling tracker: counts the ratio wait so software can see when start is safe
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg      <= ST_IDLE;
			settle_cnt_reg <= 11'h000;
		end else begin
			case (state_reg)
				ST_IDLE, ST_READY: begin
					if (cfg_wr) begin
						state_reg      <= ST_SETTLE;
						settle_cnt_reg <= 11'h000;
					end
				end
				ST_SETTLE: begin
					if (cfg_wr) begin
						settle_cnt_reg <= 11'h000;
					end else if (settle_cnt_reg + 11'h001 >= osr_cycles) begin
						state_reg <= ST_READY;
					end else begin
						settle_cnt_reg <= settle_cnt_reg + 11'h001;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// Bypassed chain needs no settling
	assign o_settled = state_reg != ST_SETTLE || bypassed;

	// Start write decode, shared by the strobe and its check
	assign start_wr = i_wr && i_addr == ADDR_ACQ_CTRL && i_wdata[START_BIT];

	// Start strobe; early starts are flagged, not blocked, since waiting is software's duty
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_conv_start    <= 1'b0;
			early_start_reg <= 1'b0;
		end else begin
			o_conv_start <= start_wr;
			if (start_wr && !o_settled) begin
				early_start_reg <= 1'b1;
			end else if (i_rd && i_addr == ADDR_ACQ_STATUS) begin
				early_start_reg <= 1'b0;
			end
		end
	end

	// Read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			if (i_addr >= ADDR_ACQ_CFG1 && i_addr <= ADDR_ACQ_CFG5) begin
				o_rdata <= cfg_reg[cfg_idx];
			end else if (i_addr == ADDR_ACQ_STATUS) begin
				o_rdata <= {5'h00, early_start_reg, o_stage_rst, o_settled};
			end else if (i_addr == ADDR_PUMP_CFG) begin
				o_rdata <= charge_pump_config_reg;
			end else begin
				o_rdata <= 8'h00;
			end
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Charge pump clock
	pump_clk_div u_div (
		.i_clk        (i_clk),
		.i_nrst       (i_nrst),
		.i_enable     (o_pump_en),
		.i_div_sel    (charge_pump_config_reg[PUMP_DIV_LSB +: 2]),
		.o_pump_tick  (o_pump_tick),
		.o_pump_phase (o_pump_phase)
	);

	// Assertions, all on the system clock and quiet while reset is held
	// Stage bypass as it stands once the current write has landed
	assign bypass_next = (cfg_wr && cfg_idx == 3'd0) ? (i_wdata[3:0] == STAGES_BYPASSED) : bypassed;

	// Cycles that settled has stayed low since the last config write; a stuck wait shows here
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			low_cnt_reg <= 11'h000;
		end else if (cfg_wr || o_settled) begin
			low_cnt_reg <= 11'h000;
		end else begin
			low_cnt_reg <= low_cnt_reg + 11'h001;
		end
	end

	// Any config write raises the gain-stage reset on the next cycle
	a_stage_reset_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
		cfg_wr |=> o_stage_rst)
		else $error("stage reset missing after config write");

	// Reset pulse lasts the two-cycle count when no further write follows
	a_stage_reset_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		cfg_wr ##1 (!cfg_wr) [*2] |-> o_stage_rst ##1 !o_stage_rst)
		else $error("stage reset length wrong");

	// A real mux change switches the input one cycle later
	a_input_switch_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
		mux_changed |=> o_input_switch)
		else $error("input switch missing");

	// No switch strobe without a mux change just before it
	a_input_switch_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_input_switch |-> $past(mux_changed))
		else $error("input switch without mux change");

	// A config write that leaves stages in use opens the wait
	a_settle_starts: assert property (@(posedge i_clk) disable iff (!i_nrst)
		cfg_wr && !bypass_next |=> !o_settled)
		else $error("settling wait not started");

	// Shortest ratio: low for exactly eight cycles when nothing else is written
	a_settle_wait_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(cfg_wr && !bypass_next && cfg_idx != 3'd2 && cfg_reg[2][RATIO_LSB +: 3] == 3'h0)
			##1 (!cfg_wr) [*8] |-> !o_settled ##1 o_settled)
		else $error("settling wait not eight cycles");

	// The wait never outlasts the programmed ratio
	a_settle_wait_end: assert property (@(posedge i_clk) disable iff (!i_nrst)
		low_cnt_reg <= osr_cycles)
		else $error("settling wait too long");

	// Bypassed chain is always ready to start
	a_bypass_settled: assert property (@(posedge i_clk) disable iff (!i_nrst)
		bypassed |-> o_settled)
		else $error("bypassed chain not settled");

	// Bypass leaves only the converter on
	a_bypass_stages_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
		bypassed |-> o_stage_en == 3'h0 && o_conv_en)
		else $error("bypass left stages on");

	// A start during the wait is recorded for software
	a_early_start_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
		start_wr && !o_settled |=> early_start_reg)
		else $error("early start not flagged");

	// Start strobe only follows a start write
	a_start_cause: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_conv_start |-> $past(start_wr))
		else $error("start strobe without start write");

	// Disabled pump never ticks
	a_pump_stops: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_pump_en |=> !o_pump_tick)
		else $error("pump ticked while disabled");

	// Disabled pump parks its phase low
	a_pump_phase_idle: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_pump_en |=> !o_pump_phase)
		else $error("pump phase not parked");

	// Divide by two ticks every other cycle while the setting holds
	a_pump_div2_rate: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(o_pump_tick && o_pump_en && charge_pump_config_reg[1:0] == 2'b00 && $stable(charge_pump_config_reg))
		##1 $stable(charge_pump_config_reg) |=> o_pump_tick)
		else $error("divide by two rate wrong");

	// Slower divisions never tick on two cycles in a row
	a_pump_tick_gap: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_pump_tick && charge_pump_config_reg[1:0] != 2'b00 && $stable(charge_pump_config_reg) |=> !o_pump_tick)
		else $error("pump ticks too close");

	// Pump comes out of reset disabled and silent
	a_reset_pump_off: assert property (@(posedge i_clk)
		$rose(i_nrst) |-> charge_pump_config_reg == PUMP_CFG_RESET && !o_pump_en && !o_pump_tick)
		else $error("pump config not cleared");

	// Main scenarios
	c_bypass_start: cover property (@(posedge i_clk) disable iff (!i_nrst) bypassed && o_conv_start);
	c_settled_start: cover property (@(posedge i_clk) disable iff (!i_nrst) $rose(o_settled) ##[1:20] o_conv_start);
	c_pump_div64: cover property (@(posedge i_clk) disable iff (!i_nrst)
		o_pump_tick && charge_pump_config_reg[1:0] == 2'b11);
	c_input_switch: cover property (@(posedge i_clk) disable iff (!i_nrst) o_input_switch);
	c_early_start: cover property (@(posedge i_clk) disable iff (!i_nrst) early_start_reg);
endmodule
`default_nettype wire

// ===== rtl/acq_pkg.sv
// Package: register map, field layout and timing constants of the acquisition control block
package acq_pkg;
	// Register addresses (8-bit register space)
	localparam logic [7:0] ADDR_ACQ_CFG1      = 8'h01;
	localparam logic [7:0] ADDR_ACQ_CFG5      = 8'h05;
	localparam logic [7:0] ADDR_ACQ_CTRL      = 8'h06;
	localparam logic [7:0] ADDR_ACQ_STATUS    = 8'h07;
	localparam logic [7:0] ADDR_PUMP_CFG      = 8'h08;
	localparam int         NUM_CFG_REGS       = 5;
	// Configuration field positions
	localparam int         STAGE_EN_LSB       = 0;   // cfg1[3:0]
	localparam int         CHAN_SEL_LSB       = 0;   // cfg2[4:0]
	localparam int         VOLT_SEL_BIT       = 5;   // cfg2[5]
	localparam int         RATIO_LSB          = 0;   // cfg3[2:0]
	localparam int         NCONV_LSB          = 3;   // cfg3[5:3]
	localparam int         AMP_IB_LSB         = 0;   // cfg4[1:0]
	localparam int         MOD_IB_LSB         = 2;   // cfg4[3:2]
	localparam int         START_BIT          = 0;   // ctrl[0]
	localparam int         PUMP_EN_BIT        = 2;
	localparam int         PUMP_DIV_LSB       = 0;
	localparam logic [3:0] STAGES_BYPASSED    = 4'h1;
	// Reset values
	localparam logic [7:0] CFG_RESET          = 8'h00;
	localparam logic [7:0] PUMP_CFG_RESET     = 8'h00;
	// Timing: gain-stage reset pulse length
	localparam int         STAGE_RST_NS       = 40;
	localparam int         CLK_PERIOD_NS      = 20;
	localparam int         STAGE_RST_CYC      = (STAGE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Oversampling ratio codes: 8 << code, 8..1024
	localparam int         RATIO_MIN_CYC      = 8;
	localparam int         RATIO_MAX_CYC      = 1024;
	// Pump divider terminal counts for /2, /4, /16, /64
	localparam logic [5:0] DIV2_TC            = 6'h01;
	localparam logic [5:0] DIV4_TC            = 6'h03;
	localparam logic [5:0] DIV16_TC           = 6'h0f;
	localparam logic [5:0] DIV64_TC           = 6'h3f;
	// Settling sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETTLE = 2'b01,
		ST_READY  = 2'b10
	} settle_state_t;
endpackage

// ===== rtl/pump_clk_div.sv
// Charge pump clock divider: enable pulses at 1/2, 1/4, 1/16 or 1/64 of the system clock
`timescale 1ns/10ps
`default_nettype none
module pump_clk_div
	import acq_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// Control
	input  wire logic       i_enable,
	input  wire logic [1:0] i_div_sel,
	// Pump drive
	output logic            o_pump_tick,
	output logic            o_pump_phase
);
	logic [5:0] cnt_reg;
	logic [5:0] tc;

	// Terminal count per division select
	always_comb begin
		case (i_div_sel)
			2'b00:   tc = DIV2_TC;
			2'b01:   tc = DIV4_TC;
			2'b10:   tc = DIV16_TC;
			default: tc = DIV64_TC;
		endcase
	end

	// Counter clears to zero while disabled so the pump stops cleanly
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_reg <= 6'h00;
		end else if (!i_enable || cnt_reg >= tc) begin
			cnt_reg <= 6'h00;
		end else begin
			cnt_reg <= cnt_reg + 6'h01;
		end
	end

	// Tick and phase toggle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pump_tick  <= 1'b0;
			o_pump_phase <= 1'b0;
		end else begin
			o_pump_tick <= i_enable && (cnt_reg >= tc);
			if (!i_enable) begin
				o_pump_phase <= 1'b0;
			end else if (cnt_reg >= tc) begin
				o_pump_phase <= ~o_pump_phase;
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/tb_acq_chain_settle_and_pump_ctrl.sv
// Self-checking bench for the acquisition chain and charge pump control block
`timescale 1ns/10ps
`default_nettype none
module tb_acq_chain_settle_and_pump_ctrl
	import acq_pkg::*;
;
	typedef struct {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] r;
		int         p;
	} row_t;
	logic       i_clk;
	logic       i_nrst;
	logic [7:0] i_addr;
	logic [7:0] i_wdata;
	logic       i_wr;
	logic       i_rd;
	logic [7:0] o_rdata;
	logic       o_stage_rst;
	logic [2:0] o_stage_en;
	logic       o_conv_en;
	logic [4:0] o_channel_mux_select;
	logic       o_voltage_mux_select;
	logic       o_input_switch;
	logic [1:0] o_amp_bias_current;
	logic [1:0] o_modulator_bias_current;
	logic [2:0] o_oversampling_ratio;
	logic [2:0] o_elementary_conversion_count;
	logic       o_conv_start;
	logic       o_settled;
	logic       o_pump_en;
	logic       o_pump_tick;
	logic       o_pump_phase;
	logic [7:0] v;
	int         n;
	int         errors;
	int         checked;
	// Address, write data, read-back, tick period (0 = no pump check)
	row_t rows [7] = '{
		'{8'h05, 8'hA5, 8'hA5, 0}, '{8'h20, 8'h55, 8'h00, 0}, '{8'h06, 8'h00, 8'h00, 0},
		'{8'h08, 8'h04, 8'h04, 2}, '{8'h08, 8'h05, 8'h05, 4}, '{8'h08, 8'h06, 8'h06, 16},
		'{8'h08, 8'hFF, 8'h07, 64}};

	acq_chain_settle_and_pump_ctrl uut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_stage_rst(o_stage_rst), .o_stage_en(o_stage_en), .o_conv_en(o_conv_en),
		.o_channel_mux_select(o_channel_mux_select), .o_voltage_mux_select(o_voltage_mux_select),
		.o_input_switch(o_input_switch), .o_amp_bias_current(o_amp_bias_current),
		.o_modulator_bias_current(o_modulator_bias_current), .o_oversampling_ratio(o_oversampling_ratio),
		.o_elementary_conversion_count(o_elementary_conversion_count), .o_conv_start(o_conv_start),
		.o_settled(o_settled), .o_pump_en(o_pump_en), .o_pump_tick(o_pump_tick), .o_pump_phase(o_pump_phase));

	// 50 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	task automatic step;
		@(posedge i_clk);
		#1;
	endtask

	// One-cycle write strobe, returns just after the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	// Read data only stand in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t value got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		checked++;
		if (got != exp) begin
			errors++;
			$display("MISMATCH t=%0t count got %0d exp %0d", $time, got, exp);
		end
	endtask

	// Cycles between two pump ticks; bounded so a dead divider cannot hang
	task automatic gap(output int c);
		c = 0;
		while (o_pump_tick !== 1'b1 && c < 200) begin
			step;
			c++;
		end
		c = 0;
		do begin
			step;
			c++;
		end while (o_pump_tick !== 1'b1 && c < 200);
	endtask

	// Cycles that the settled flag stays low
	task automatic settle(output int c);
		c = 0;
		while (o_settled !== 1'b1 && c < 2000) begin
			c++;
			step;
		end
	endtask

	task automatic wrap_up;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog: whole run needs well under a thousand cycles
	initial begin
		#400000;
		errors++;
		wrap_up;
	end

	initial begin
		errors = 0;
		checked = 0;
		i_nrst = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		repeat (6) @(posedge i_clk);
		chk({7'b0, o_settled}, 8'h01);
		chk({7'b0, o_pump_en}, 8'h00);
		i_nrst <= 1'b1;
		rd(ADDR_PUMP_CFG, v);
		chk(v, PUMP_CFG_RESET);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			chk(v, rows[i].r);
			if (rows[i].p != 0) begin
				gap(n);
				chk_cnt(n, rows[i].p);
			end
		end
		// Pump stopped: no ticks and phase parked low
		wr(ADDR_PUMP_CFG, 8'h03);
		chk({7'b0, o_pump_en}, 8'h00);
		n = 0;
		repeat (130) begin
			step;
			if (o_pump_tick !== 1'b0 || o_pump_phase !== 1'b0) n++;
		end
		chk_cnt(n, 0);
		for (int a = 1; a <= 5; a++) begin
			wr(a[7:0], 8'h00);
			n = 0;
			while (o_stage_rst === 1'b1 && n < 10) begin
				n++;
				step;
			end
			chk_cnt(n, STAGE_RST_CYC);
		end
		// Mux changes switch the input; upper bits alone do not
		wr(8'h02, 8'h2A);
		chk({7'b0, o_input_switch}, 8'h01);
		chk({3'b0, o_channel_mux_select}, 8'h0A);
		chk({7'b0, o_voltage_mux_select}, 8'h01);
		wr(8'h02, 8'hEA);
		chk({7'b0, o_input_switch}, 8'h00);
		wr(8'h02, 8'hCA);
		chk({7'b0, o_input_switch}, 8'h01);
		for (int c = 0; c < 3; c++) begin
			wr(8'h03, 8'h18 | c[7:0]);
			chk({5'b0, o_elementary_conversion_count}, 8'h03);
			chk({5'b0, o_oversampling_ratio}, c[7:0]);
			settle(n);
			wr(8'h01, 8'h0F);
			settle(n);
			chk_cnt(n, RATIO_MIN_CYC << c);
		end
		// Early start is flagged, not blocked; status flag clears on read
		wr(8'h01, 8'h0F);
		chk({5'b0, o_stage_en}, 8'h07);
		wr(ADDR_ACQ_CTRL, 8'h01);
		chk({7'b0, o_conv_start}, 8'h01);
		step;
		chk({7'b0, o_conv_start}, 8'h00);
		rd(ADDR_ACQ_STATUS, v);
		chk(v & 8'h04, 8'h04);
		rd(ADDR_ACQ_STATUS, v);
		chk(v & 8'h04, 8'h00);
		settle(n);
		wr(8'h01, 8'h01);
		chk({5'b0, o_stage_en}, 8'h00);
		chk({7'b0, o_conv_en}, 8'h01);
		chk({7'b0, o_settled}, 8'h01);
		wr(8'h04, 8'h0E);
		chk({4'b0, o_modulator_bias_current, o_amp_bias_current}, 8'h0E);
		wr(8'h04, 8'h0F);
		chk({4'b0, o_modulator_bias_current, o_amp_bias_current}, 8'h0F);
		// Reset in mid-run clears the pump setting
		wr(ADDR_PUMP_CFG, 8'h06);
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk({7'b0, o_pump_en}, 8'h00);
		i_nrst <= 1'b1;
		rd(ADDR_PUMP_CFG, v);
		chk(v, 8'h00);
		wrap_up;
	end
endmodule
`default_nettype wire
